/* File: design/uhtm_cfg.svh */
`ifndef UHTM_CFG_SVH
`define UHTM_CFG_SVH

// Register byte offsets.
`define UHTM_ADDR_TEST  8'h50
`define UHTM_ADDR_DCTL  8'h70
`define UHTM_ADDR_DPTR  8'h74
`define UHTM_ADDR_ISTS  8'hA0
`define UHTM_ADDR_IMSK  8'hA4

// Field positions of the port test control register.
`define UHTM_BIT_J      0
`define UHTM_BIT_K      1
`define UHTM_BIT_PKT    2
`define UHTM_BIT_LOOP   4

// Field positions of the test DMA control register.
`define UHTM_BIT_START  0
`define UHTM_BIT_DIR    1
`define UHTM_LEN_LSB    8
`define UHTM_LEN_MSB    24
`define UHTM_LEN_MAX    10'h3FF

// Field position of the transfer done flag and its mask bit.
`define UHTM_BIT_DONE   2

// Reset values.
`define UHTM_RST_WORD   32'h0000_0000

// Timing: least spacing between two writes to one test register.
`define UHTM_CLK_NS     20
`define UHTM_WR_GAP_NS  150
`define UHTM_WR_GAP_CYC ((`UHTM_WR_GAP_NS + `UHTM_CLK_NS - 1) / `UHTM_CLK_NS)

`endif

/* File: design/uhtm_pkg.sv */
package uhtm_pkg;

    // States of the test DMA and packet sender.
    typedef enum logic [1:0] {
        UHTM_IDLE   = 2'b00,
        UHTM_MEM_RD = 2'b01,
        UHTM_MEM_WR = 2'b10,
        UHTM_TX     = 2'b11
    } uhtm_dma_state_t;

    // State of the test mode block, apart from the packet FIFO storage.
    typedef struct packed {
        logic            ack;
        logic [31:0]     rdata;
        logic [3:0]      gap;
        logic            loop;
        logic            pkt;
        logic            fk;
        logic            fj;
        logic [16:0]     len;
        logic            dir;
        logic            start;
        logic [31:0]     ptr;
        logic            done_flag;
        logic            done_mask;
        uhtm_dma_state_t st;
        logic [9:0]      idx;
        logic [9:0]      total;
        logic            mem_req;
        logic            mem_we;
        logic [31:0]     mem_addr;
        logic [7:0]      mem_wdata;
        logic            tx_valid;
        logic [7:0]      tx_data;
        logic            tx_last;
    } uhtm_state_t;

endpackage

/* File: design/uhtm_top.sv */
// Our own choice: register access over Avalon-MM.
`include "uhtm_cfg.svh"

// Overview of operation
// [RQ1] Setting the loopback bit (bit 4) of the test register puts the port in loopback mode.
// [RQ2] Writing one to bit 0 of the test register forces the lines to the high-speed J state.
// [RQ3] Writing one to bit 1 of the test register forces the lines to the high-speed K state.
// [RQ4] In high speed with bit 2 set, software programs both DMA registers to load the packet.
// [RQ5] In test packet mode, once the DMA has filled the FIFO, the packet goes to the transceiver.
// [RQ6] Software keeps at most one test bit of the test register set at a time.
// [RQ7] Software leaves at least 150 ns between two writes to the same test register.
// [RQ8] Bits 24 to 8 of the DMA control register hold the byte count, at most 1023.
// [RQ9] Bit 1 of the DMA control register picks the direction: 0 FIFO to memory, 1 the reverse.
// [RQ10] Setting bit 0 of the DMA control register starts the programmed transfer.
// [RQ11] The full 32-bit pointer register is the memory address where the transfer begins.
// [RQ12] Both DMA registers act only in test packet mode.
// [RQ13] A finished transfer sets the done flag at status bit 2, and raises irq when enabled.
// [RQ14] The start bit clears itself once the whole byte count has moved.
module uhtm_top (
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic [7:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    input  wire logic [3:0]             byteenable,
    output logic [31:0]                 readdata,
    output logic                        waitrequest,
    output logic                        irq,
    output logic                        loopback_en,
    output logic                        line_force_j,
    output logic                        line_force_k,
    output logic                        packet_mode,
    output logic                        mem_req,
    output logic                        mem_we,
    output logic [31:0]                 mem_addr,
    output logic [7:0]                  mem_wdata,
    input  wire logic [7:0]             mem_rdata,
    input  wire logic                   mem_ack,
    output logic                        tx_valid,
    output logic [7:0]                  tx_data,
    output logic                        tx_last,
    input  wire logic                   tx_ready,
    output uhtm_pkg::uhtm_dma_state_t   dma_state
);
    import uhtm_pkg::*;

    localparam int FIFO_DEPTH = 1024;

    uhtm_state_t s;
    uhtm_state_t n;
    logic [7:0]  fifo_mem [FIFO_DEPTH];
    logic        fifo_we;
    logic        done_evt;
    logic        accept;
    logic        block;

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Limits the programmed byte count to the largest legal transfer.
    function automatic logic [9:0] clamp_len(input logic [16:0] len);
        return (len > 17'(`UHTM_LEN_MAX)) ? `UHTM_LEN_MAX : len[9:0];
    endfunction

    // Tells whether an offset is one of the write-spaced test registers.
    function automatic logic is_spaced(input logic [7:0] a);
        return (a == `UHTM_ADDR_TEST) || (a == `UHTM_ADDR_DCTL) || (a == `UHTM_ADDR_DPTR);
    endfunction

    // Bus answer: one wait state, longer for a write to a spaced register while one is still settling.
    assign accept      = (read | write) & ~s.ack;
    assign block       = write & is_spaced(address) & (s.gap != 4'h0); // RQ7
    assign waitrequest = (read | write) & ~s.ack;
    assign readdata    = s.rdata;

    // Next state of registers, bus and DMA engine.
    always_comb begin
        logic [31:0] w;
        logic        w1c;
        w        = `UHTM_RST_WORD;
        w1c      = 1'b0;
        n        = s;
        fifo_we  = 1'b0;
        done_evt = 1'b0;
        n.ack    = accept & ~block;
        n.gap    = (s.gap != 4'h0) ? s.gap - 4'h1 : 4'h0;

        // Read data is captured on the edge that also raises the answer.
        if (accept & ~block & read) begin
            case (address)
                `UHTM_ADDR_TEST: n.rdata = {27'h0, s.loop, 1'b0, s.pkt, s.fk, s.fj};
                `UHTM_ADDR_DCTL: n.rdata = {7'h00, s.len, 6'h00, s.dir, s.start};
                `UHTM_ADDR_DPTR: n.rdata = s.ptr;
                `UHTM_ADDR_ISTS: n.rdata = {29'h0, s.done_flag, 2'h0};
                `UHTM_ADDR_IMSK: n.rdata = {29'h0, s.done_mask, 2'h0};
                default:         n.rdata = 32'h0000_0000;
            endcase
        end

        // Writes take effect on the edge where waitrequest is seen low.
        if (s.ack & write) begin
            if (is_spaced(address)) begin
                n.gap = 4'(`UHTM_WR_GAP_CYC); // RQ7
            end
            case (address)
                `UHTM_ADDR_TEST: begin
                    w      = be_merge({27'h0, s.loop, 1'b0, s.pkt, s.fk, s.fj}, writedata,
                                      byteenable);
                    n.loop = w[`UHTM_BIT_LOOP]; // RQ1
                    n.pkt  = w[`UHTM_BIT_PKT];
                    n.fk   = w[`UHTM_BIT_K]; // RQ3
                    n.fj   = w[`UHTM_BIT_J]; // RQ2
                end
                `UHTM_ADDR_DCTL: begin
                    w     = be_merge({7'h00, s.len, 6'h00, s.dir, s.start}, writedata,
                                     byteenable);
                    n.len = w[`UHTM_LEN_MSB:`UHTM_LEN_LSB]; // RQ8
                    n.dir = w[`UHTM_BIT_DIR]; // RQ9
                    n.start = s.start | (w[`UHTM_BIT_START] & s.pkt &
                                         (s.st == UHTM_IDLE)); // RQ10 RQ12
                end
                `UHTM_ADDR_DPTR: n.ptr = be_merge(s.ptr, writedata, byteenable); // RQ11
                `UHTM_ADDR_ISTS: w1c = byteenable[0] & writedata[`UHTM_BIT_DONE];
                `UHTM_ADDR_IMSK: begin
                    if (byteenable[0]) begin
                        n.done_mask = writedata[`UHTM_BIT_DONE];
                    end
                end
                default: w1c = 1'b0;
            endcase
        end

        // DMA engine and packet sender.
        case (s.st)
            UHTM_IDLE: begin
                if (s.start) begin
                    n.idx   = 10'h000;
                    n.total = clamp_len(s.len); // RQ8
                    if (clamp_len(s.len) == 10'h000) begin
                        n.start  = 1'b0; // RQ14
                        done_evt = 1'b1;
                    end else if (s.dir) begin
                        n.st       = UHTM_MEM_RD; // RQ9
                        n.mem_req  = 1'b1;
                        n.mem_addr = s.ptr; // RQ11
                    end else begin
                        n.st        = UHTM_MEM_WR;
                        n.mem_req   = 1'b1;
                        n.mem_we    = 1'b1;
                        n.mem_addr  = s.ptr; // RQ11
                        n.mem_wdata = fifo_mem[0];
                    end
                end
            end
            UHTM_MEM_RD: begin
                if (mem_ack) begin
                    fifo_we = 1'b1;
                    if (s.idx == s.total - 10'h001) begin
                        n.start    = 1'b0; // RQ14
                        done_evt   = 1'b1;
                        n.mem_req  = 1'b0;
                        n.st       = UHTM_TX; // RQ5
                        n.idx      = 10'h000;
                        n.tx_valid = 1'b1;
                        n.tx_data  = (s.idx == 10'h000) ? mem_rdata : fifo_mem[0];
                        n.tx_last  = (s.total == 10'h001);
                    end else begin
                        n.idx      = s.idx + 10'h001;
                        n.mem_addr = s.mem_addr + 32'h0000_0001;
                    end
                end
            end
            UHTM_MEM_WR: begin
                if (mem_ack) begin
                    if (s.idx == s.total - 10'h001) begin
                        n.start   = 1'b0; // RQ14
                        done_evt  = 1'b1;
                        n.mem_req = 1'b0;
                        n.mem_we  = 1'b0;
                        n.st      = UHTM_IDLE;
                    end else begin
                        n.idx       = s.idx + 10'h001;
                        n.mem_addr  = s.mem_addr + 32'h0000_0001;
                        n.mem_wdata = fifo_mem[s.idx + 10'h001];
                    end
                end
            end
            UHTM_TX: begin
                if (tx_ready) begin
                    if (s.tx_last) begin
                        n.tx_valid = 1'b0;
                        n.tx_last  = 1'b0;
                        n.st       = UHTM_IDLE;
                    end else begin
                        n.idx     = s.idx + 10'h001;
                        n.tx_data = fifo_mem[s.idx + 10'h001]; // RQ5
                        n.tx_last = ((s.idx + 10'h002) == s.total);
                    end
                end
            end
            default: n.st = UHTM_IDLE;
        endcase

        // Leaving test packet mode abandons any transfer under way.
        if (!s.pkt && (s.st != UHTM_IDLE)) begin
            n.st       = UHTM_IDLE; // RQ12
            n.start    = 1'b0;
            n.mem_req  = 1'b0;
            n.mem_we   = 1'b0;
            n.tx_valid = 1'b0;
            n.tx_last  = 1'b0;
        end

        // A completion in the same cycle as a clear keeps the flag set.
        n.done_flag = (s.done_flag & ~w1c) | done_evt; // RQ13
    end

    // State register with synchronous reset.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Packet FIFO storage filled by the memory-to-FIFO transfer.
    always_ff @(posedge clock) begin
        if (fifo_we) begin
            fifo_mem[s.idx] <= mem_rdata;
        end
    end

    // Outputs from the state register, irq as the done flag gated by its mask.
    assign irq          = s.done_flag & s.done_mask; // RQ13
    assign loopback_en  = s.loop; // RQ1
    assign line_force_j = s.fj; // RQ2
    assign line_force_k = s.fk; // RQ3
    assign packet_mode  = s.pkt;
    assign mem_req      = s.mem_req;
    assign mem_we       = s.mem_we;
    assign mem_addr     = s.mem_addr;
    assign mem_wdata    = s.mem_wdata;
    assign tx_valid     = s.tx_valid;
    assign tx_data      = s.tx_data;
    assign tx_last      = s.tx_last;
    assign dma_state    = s.st;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Checks of the block's own behaviour.
    loop_follows_write_a: assert property ( // RQ1
        (s.ack && write && address == `UHTM_ADDR_TEST && byteenable[0])
        |=> (loopback_en == $past(writedata[`UHTM_BIT_LOOP])))
        else $error("loopback enable does not follow the written bit");
    j_follows_write_a: assert property ( // RQ2
        (s.ack && write && address == `UHTM_ADDR_TEST && byteenable[0])
        |=> (line_force_j == $past(writedata[`UHTM_BIT_J])))
        else $error("forced J state does not follow the written bit");
    k_follows_write_a: assert property ( // RQ3
        (s.ack && write && address == `UHTM_ADDR_TEST && byteenable[0])
        |=> (line_force_k == $past(writedata[`UHTM_BIT_K])))
        else $error("forced K state does not follow the written bit");
    send_after_load_a: assert property ( // RQ5
        (s.st == UHTM_MEM_RD && mem_ack && s.idx == s.total - 10'h001 && s.pkt)
        |=> (tx_valid && dma_state == UHTM_TX && !mem_req))
        else $error("packet not sent after the FIFO load");
    count_limit_a: assert property ( // RQ8
        $rose(mem_req) |-> (s.total == clamp_len(s.len) && s.total != 10'h000))
        else $error("transfer length not taken from the clamped count");
    direction_a: assert property ( // RQ9
        $rose(mem_req) |-> (mem_we == !s.dir))
        else $error("transfer direction does not match the direction bit");
    start_begins_a: assert property ( // RQ10
        ($rose(s.start) && s.pkt && clamp_len(s.len) != 10'h000) |=> mem_req)
        else $error("start bit did not begin the transfer");
    address_walk_a: assert property ( // RQ11
        mem_req |-> (mem_addr == s.ptr + {22'h0, s.idx}))
        else $error("memory address does not walk from the pointer");
    packet_only_a: assert property ( // RQ12
        mem_req |-> $past(s.pkt))
        else $error("DMA active outside test packet mode");
    done_irq_a: assert property ( // RQ13
        done_evt |=> (s.done_flag ##0 (irq == s.done_mask)))
        else $error("done flag or interrupt missing after completion");
    start_clears_a: assert property ( // RQ14
        done_evt |=> !s.start)
        else $error("start bit did not clear at completion");

    // Main scenarios to be reached.
    load_then_send_c: cover property ($rose(mem_req) && !mem_we ##[1:300] (tx_valid && tx_last));
    fifo_to_mem_c: cover property ($rose(mem_we) ##[1:300] done_evt);
    irq_raised_c: cover property ($rose(irq));
    spaced_write_c: cover property (block);
endmodule

/* File: testbench/uhtm_mem_model.sv */
// Memory and transceiver standing beyond the test DMA of the port.
module uhtm_mem_model (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    output logic      [7:0]  mem_rdata,
    output logic             mem_ack,
    input  wire logic        tx_valid,
    output logic             tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    logic [7:0] last = 8'h3C;
    // Free running pattern; in slow mode the far side stalls often.
    always @(posedge clock) cnt <= rstn ? cnt + 4'h1 : 4'h0;
    // Memory acknowledges each byte at the requested address.
    assign mem_ack = mem_req && (!slow || cnt[1:0] == 2'b01);
    // Read bytes follow an address pattern; otherwise the bus shows junk.
    assign mem_rdata = (mem_ack && !mem_we) ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5) : ~last;
    always @(posedge clock) if (mem_ack && !mem_we) last <= mem_rdata;
    // Transceiver takes packet bytes, stalling in slow mode.
    assign tx_ready = tx_valid && (!slow || cnt[0]);
endmodule

/* File: testbench/usb_host_port_test_mode_tb.sv */
`include "uhtm_cfg.svh"
// Self-checking bench of the port test mode block.
module usb_host_port_test_mode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uhtm_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, slow = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, mem_addr, seed = 32'hDA477DEC, q;
    logic waitrequest, irq, loopback_en, line_force_j, line_force_k, packet_mode;
    logic mem_req, mem_we, mem_ack, tx_valid, tx_last, tx_ready;
    logic [7:0] mem_wdata, mem_rdata, tx_data;
    uhtm_dma_state_t dma_state;
    int errors = 0, comparisons = 0, cyc = 0, nlast;
    logic [31:0] ma[$];
    logic [7:0] md[$], tq[$], fifo[1024];
    uhtm_top i_uhtm_top (.clock(clock), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .loopback_en(loopback_en),
        .line_force_j(line_force_j), .line_force_k(line_force_k), .packet_mode(packet_mode),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .dma_state(dma_state));
    uhtm_mem_model i_uhtm_mem_model (.clock(clock), .rstn(rstn), .slow(slow),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // Clock of 20 ns and a cycle counter that cuts a hang short.
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            complete_run();
        end
    end
    // Record memory bytes and packet bytes as they are taken.
    always @(posedge clock) if (rstn) begin
        if (mem_req && mem_ack) begin
            ma.push_back(mem_addr);
            md.push_back(mem_we ? mem_wdata : 8'h00);
        end
        if (tx_valid && tx_ready) begin
            tq.push_back(tx_data);
            if (tx_last) nlast++;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low at an edge.
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        // The request stands until waitrequest is sampled low at a rising edge.
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (w && a < 8'h80) repeat (8) @(posedge clock);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Run one DMA and compare memory, packet, status and interrupt with the model.
    task automatic dma(input int n, input bit dir, input bit msk);
        int c, k;
        logic [31:0] p;
        seed = lfsr(seed);
        p = seed;
        c = (n > 1023) ? 1023 : n;
        ma.delete(); md.delete(); tq.delete(); nlast = 0;
        bus(1'b1, `UHTM_ADDR_IMSK, {29'h0, msk, 2'b00});
        bus(1'b1, `UHTM_ADDR_DPTR, p);
        bus(1'b1, `UHTM_ADDR_DCTL, (n << 8) | (dir << 1) | 1);
        k = 0;
        do begin
            bus(1'b0, `UHTM_ADDR_DCTL, 32'h0);
            k++;
        end while (q[0] !== 1'b0 && k < 3000);
        chk(q, (n << 8) | (dir << 1));
        k = 0;
        while (dma_state !== UHTM_IDLE && k < 3000) begin
            @(posedge clock);
            k++;
        end
        chk(ma.size(), c);
        chk(tq.size(), dir ? c : 0);
        for (int i = 0; i < c; i++) begin
            chk(ma[i], p + i);
            if (dir) begin
                fifo[i] = (p + i) ^ ((p + i) >> 8) ^ 8'hA5;
                chk(tq[i], fifo[i]);
            end else chk(md[i], fifo[i]);
        end
        chk(nlast, (dir && c > 0) ? 1 : 0);
        rdchk(`UHTM_ADDR_ISTS, 32'h4);
        chk(irq, msk);
        bus(1'b1, `UHTM_ADDR_ISTS, 32'h4);
        @(negedge clock);
        chk(irq, 1'b0);
        rdchk(`UHTM_ADDR_ISTS, 32'h0);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        logic [4:0] modes [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        // Every register reads zero after reset, unmapped places too.
        rdchk(`UHTM_ADDR_TEST, 32'h0);
        rdchk(`UHTM_ADDR_ISTS, 32'h0);
        rdchk(`UHTM_ADDR_IMSK, 32'h0);
        rdchk(`UHTM_ADDR_DCTL, 32'h0);
        rdchk(`UHTM_ADDR_DPTR, 32'h0);
        rdchk(8'h10, 32'h0);
        // Each test mode alone drives its own output; reserved bits stay zero.
        foreach (modes[i]) begin
            bus(1'b1, `UHTM_ADDR_TEST, 32'hFFFF_FFE8 | modes[i]);
            rdchk(`UHTM_ADDR_TEST, {27'h0, modes[i]});
            chk({loopback_en, packet_mode, line_force_k, line_force_j},
                {modes[i][4], modes[i][2:0]});
        end
        // Start outside packet mode is ignored.
        bus(1'b1, `UHTM_ADDR_TEST, 32'h0);
        bus(1'b1, `UHTM_ADDR_DCTL, 32'h403);
        chk(mem_req, 1'b0);
        rdchk(`UHTM_ADDR_DCTL, 32'h402);
        bus(1'b1, `UHTM_ADDR_TEST, 32'h4);
        dma(0, 1'b1, 1'b1);
        dma(1100, 1'b1, 1'b0);
        for (int r = 0; r < 6; r++) begin
            seed = lfsr(seed);
            slow <= seed[0];
            dma(1 + seed[4:1], r[0], seed[5]);
        end
        // Leaving packet mode mid-transfer aborts without a done flag.
        bus(1'b1, `UHTM_ADDR_DCTL, 32'h1F403);
        bus(1'b1, `UHTM_ADDR_TEST, 32'h0);
        repeat (2) @(posedge clock);
        chk({mem_req, tx_valid}, 2'b00);
        rdchk(`UHTM_ADDR_ISTS, 32'h0);
        complete_run();
    end
endmodule
